// [hdl/ccti_timer.v]
// Four-channel 16-bit capture/compare timer with prescaled counter.
// Assumes a plain register port on mclk_in; channel pins are async.
`timescale 1ns/10ps
`include "ccti_defs.vh"
module ccti_timer #(
	parameter PRE_W = `CCTI_PRE_W
) (
	// Clock, reset, enable
	input wire mclk_in,
	input wire nrst_in,
	input wire ce_in,
	// Register port
	input wire [`CCTI_AW-1:0] addr_in,
	input wire [`CCTI_DW-1:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	output reg [`CCTI_DW-1:0] rd_data_out,
	// Channel pins
	input wire [`CCTI_NCH-1:0] pin_in,
	output reg [`CCTI_NCH-1:0] pin_out,
	output reg [`CCTI_NCH-1:0] pin_oe_out,
	// Interrupt requests
	output reg [`CCTI_NCH-1:0] chan_irq_out,
	output reg ovf_irq_out
);

////////////////////////////////////////////////////////////////////////

function hit;
	input [`CCTI_AW-1:0] a;
	input [`CCTI_AW-1:0] base;
	begin
		hit = (a == base);
	end
endfunction

function compare_action;
	input [1:0] ml;
	input cur;
	begin
		case (ml)
			`CCTI_ACT_TOGGLE: compare_action = ~cur;
			`CCTI_ACT_CLEAR: compare_action = 1'b0;
			`CCTI_ACT_SET: compare_action = 1'b1;
			default: compare_action = cur;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////

reg [7:0] system_control_two;
reg [`CCTI_NCH-1:0] channel_direction_select;
reg [`CCTI_NCH-1:0] compare_mode_bit;
reg [`CCTI_NCH-1:0] compare_level_bit;
reg [`CCTI_NCH-1:0] interrupt_enable_register;
reg [`CCTI_NCH-1:0] channel_event_flag;
reg overflow_flag;
reg [`CCTI_NCH-1:0] mask3;
reg [`CCTI_NCH-1:0] data3;
reg [`CCTI_NCH-1:0] port_latch;
reg [2*`CCTI_NCH-1:0] edge_cfg;
reg [`CCTI_DW-1:0] free_running_counter;
reg [PRE_W-1:0] prescale;
reg tick_d;
reg [`CCTI_NCH-1:0] oc_state;
reg [`CCTI_DW-1:0] tc [0:`CCTI_NCH-1];

wire [`CCTI_NCH-1:0] pin_lvl;
wire [`CCTI_NCH-1:0] pin_rise;
wire [`CCTI_NCH-1:0] pin_fall;

wire [2:0] divisor_select =
	system_control_two[`CCTI_F_DIV_HI:`CCTI_F_DIV_LO];
wire counter_reset_enable = system_control_two[`CCTI_F_COUNTER_RESET_ENABLE];
wire fast_flag_clear_all = system_control_two[`CCTI_F_FFCA];
wire overflow_interrupt_enable = system_control_two[`CCTI_F_TOI];
wire timer_enable = system_control_two[`CCTI_F_TEN];

////////////////////////////////////////////////////////////////////////
// Pin edge detection, one per channel

genvar g;
generate
	for (g = 0; g < `CCTI_NCH; g = g + 1) begin : g_edge
		ccti_edge u_edge (
			.mclk_in(mclk_in),
			.nrst_in(nrst_in),
			.ce_in(ce_in),
			.pin_in(pin_in[g]),
			.level_out(pin_lvl[g]),
			.rise_out(pin_rise[g]),
			.fall_out(pin_fall[g])
		);
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// Prescaler and counter

// Low prescale bits (count set by divisor_select) all ones marks the tick
wire [PRE_W-1:0] pre_mask =
	`CCTI_PRE_MAX >> (`CCTI_DIV_TOP - divisor_select);
wire tick = timer_enable & ((prescale & pre_mask) == pre_mask);

wire wr_tc = wr_in & ((addr_in & `CCTI_A_TC_MASK) == `CCTI_A_TC0);
wire [1:0] tc_idx = addr_in[1:0];
wire cnt_access = (wr_in | rd_in) & hit(addr_in, `CCTI_A_CNT);

// Match checked in the cycle after the counter moved
reg [`CCTI_NCH-1:0] match;
reg [`CCTI_NCH-1:0] capture;
// One loop variable per process, so no @* block wakes another
integer i;
integer j;
integer k;
always @* begin
	for (i = 0; i < `CCTI_NCH; i = i + 1) begin
		match[i] = tick_d & channel_direction_select[i] &
			(free_running_counter == tc[i]);
		capture[i] = ~channel_direction_select[i] &
			((edge_cfg[2*i] & pin_rise[i]) |
			(edge_cfg[2*i+1] & pin_fall[i]));
	end
end

wire cnt_reset = counter_reset_enable & match[3];
wire ovf_set = tick & ~cnt_reset &
	(free_running_counter == `CCTI_CNT_MAX);

////////////////////////////////////////////////////////////////////////
// Compare outputs

wire [`CCTI_NCH-1:0] force_compare_bit = (wr_in &
	hit(addr_in, `CCTI_A_FORCE)) ?
	(wr_data_in[`CCTI_NCH-1:0] & channel_direction_select) :
	`CCTI_NIB_RST;
wire [`CCTI_NCH-1:0] connected = compare_mode_bit | compare_level_bit;

reg [`CCTI_NCH-1:0] next_oc;
always @* begin
	next_oc = oc_state;
	for (j = 0; j < `CCTI_NCH; j = j + 1) begin
		if (match[j] | force_compare_bit[j])
			next_oc[j] = compare_action({compare_mode_bit[j],
				compare_level_bit[j]}, oc_state[j]);
	end
	// Channel 3 applied last so it wins over the others
	if (match[3] | force_compare_bit[3]) begin
		for (j = 0; j < `CCTI_NCH - 1; j = j + 1) begin
			if (mask3[j] & channel_direction_select[j])
				next_oc[j] = data3[j];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Flags; a set in the clearing cycle wins

wire [`CCTI_NCH-1:0] flag_clr = (wr_in & hit(addr_in, `CCTI_A_FLAG)) ?
	wr_data_in[`CCTI_NCH-1:0] : `CCTI_NIB_RST;
wire [`CCTI_NCH-1:0] next_flag =
	(channel_event_flag & ~flag_clr) | match | capture;
wire ovf_clr = (wr_in & hit(addr_in, `CCTI_A_OVF) & wr_data_in[0]) |
	(fast_flag_clear_all & cnt_access);
wire next_ovf = (overflow_flag & ~ovf_clr) | ovf_set;

////////////////////////////////////////////////////////////////////////
// Next register values seen by the registered outputs

// pin_oe_out and the requests take a DIR, IE or CTRL write at the same edge as the register
wire wr_dir = wr_in & hit(addr_in, `CCTI_A_DIR);
wire wr_ie = wr_in & hit(addr_in, `CCTI_A_IE);
wire wr_ctrl = wr_in & hit(addr_in, `CCTI_A_CTRL);
wire [`CCTI_NCH-1:0] next_dir = wr_dir ?
	wr_data_in[`CCTI_NCH-1:0] : channel_direction_select;
wire [`CCTI_NCH-1:0] next_ie = wr_ie ?
	wr_data_in[`CCTI_NCH-1:0] : interrupt_enable_register;
wire next_toi = wr_ctrl ? wr_data_in[`CCTI_F_TOI] :
	overflow_interrupt_enable;

////////////////////////////////////////////////////////////////////////
// Read mux
// Force register is write-only and reads as zero

reg [`CCTI_DW-1:0] next_rd;
always @* begin
	next_rd = `CCTI_ZERO16;
	if (rd_in) begin
		case (addr_in)
			`CCTI_A_CTRL: next_rd[7:0] = system_control_two;
			`CCTI_A_DIR: next_rd[3:0] = channel_direction_select;
			`CCTI_A_MODE: next_rd[3:0] = compare_mode_bit;
			`CCTI_A_LEVEL: next_rd[3:0] = compare_level_bit;
			`CCTI_A_IE: next_rd[3:0] = interrupt_enable_register;
			`CCTI_A_FLAG: next_rd[3:0] = channel_event_flag;
			`CCTI_A_OVF: next_rd[0] = overflow_flag;
			`CCTI_A_CNT: next_rd = free_running_counter;
			`CCTI_A_MASK3: next_rd[3:0] = mask3;
			`CCTI_A_DATA3: next_rd[3:0] = data3;
			`CCTI_A_LATCH: next_rd[3:0] = port_latch;
			`CCTI_A_EDGE: next_rd[7:0] = edge_cfg;
			`CCTI_A_PINS: next_rd[3:0] = pin_lvl;
			default: begin
				if ((addr_in & `CCTI_A_TC_MASK) == `CCTI_A_TC0)
					next_rd = tc[tc_idx];
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// State

always @(posedge mclk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		system_control_two <= `CCTI_CTRL_RST;
		channel_direction_select <= `CCTI_NIB_RST;
		compare_mode_bit <= `CCTI_NIB_RST;
		compare_level_bit <= `CCTI_NIB_RST;
		interrupt_enable_register <= `CCTI_NIB_RST;
		channel_event_flag <= `CCTI_NIB_RST;
		overflow_flag <= 1'b0;
		mask3 <= `CCTI_NIB_RST;
		data3 <= `CCTI_NIB_RST;
		port_latch <= `CCTI_NIB_RST;
		edge_cfg <= `CCTI_EDGE_RST;
		free_running_counter <= `CCTI_ZERO16;
		prescale <= {PRE_W{1'b0}};
		tick_d <= 1'b0;
		oc_state <= `CCTI_NIB_RST;
		for (k = 0; k < `CCTI_NCH; k = k + 1)
			tc[k] <= `CCTI_ZERO16;
		rd_data_out <= `CCTI_ZERO16;
		pin_out <= `CCTI_NIB_RST;
		pin_oe_out <= `CCTI_NIB_RST;
		chan_irq_out <= `CCTI_NIB_RST;
		ovf_irq_out <= 1'b0;
	end else if (ce_in) begin
		if (wr_in) begin
			case (addr_in)
				`CCTI_A_CTRL: system_control_two <= wr_data_in[7:0];
				`CCTI_A_DIR: channel_direction_select <= wr_data_in[3:0];
				`CCTI_A_MODE: compare_mode_bit <= wr_data_in[3:0];
				`CCTI_A_LEVEL: compare_level_bit <= wr_data_in[3:0];
				`CCTI_A_IE: interrupt_enable_register <= wr_data_in[3:0];
				`CCTI_A_MASK3: mask3 <= wr_data_in[3:0];
				`CCTI_A_DATA3: data3 <= wr_data_in[3:0];
				`CCTI_A_LATCH: port_latch <= wr_data_in[3:0];
				`CCTI_A_EDGE: edge_cfg <= wr_data_in[7:0];
				default: ;
			endcase
		end
		// Prescaler restarts from zero whenever the timer is stopped
		prescale <= timer_enable ? prescale + 1'b1 : {PRE_W{1'b0}};
		tick_d <= tick;
		if (cnt_reset)
			free_running_counter <= `CCTI_ZERO16;
		else if (tick)
			free_running_counter <= free_running_counter + 1'b1;
		for (k = 0; k < `CCTI_NCH; k = k + 1) begin
			if (capture[k])
				tc[k] <= free_running_counter;
			else if (wr_tc && tc_idx == k && channel_direction_select[k])
				tc[k] <= wr_data_in;
		end
		channel_event_flag <= next_flag;
		overflow_flag <= next_ovf;
		oc_state <= next_oc;
		// Disconnected compare pin falls back to the port latch
		pin_out <= (connected & next_oc) |
			(~connected & port_latch);
		// Capture channels leave their pin undriven
		pin_oe_out <= next_dir;
		// Requests are levels, dropped by clearing the flag or its enable
		chan_irq_out <= next_flag & next_ie;
		ovf_irq_out <= next_ovf & next_toi;
		rd_data_out <= next_rd;
	end
end

endmodule

// [hdl/ccti_defs.vh]
// Constants for the four-channel capture/compare timer.
// Assumes inclusion by bare name from the timer, its checker and its bench.
`ifndef CCTI_DEFS_VH
`define CCTI_DEFS_VH

// Bus and datapath widths
`define CCTI_AW 8
`define CCTI_DW 16
`define CCTI_NCH 4
`define CCTI_PRE_W 7

// Register offsets (word index on the plain port)
`define CCTI_A_CTRL 8'h00
`define CCTI_A_DIR 8'h01
`define CCTI_A_FORCE 8'h02
`define CCTI_A_MODE 8'h03
`define CCTI_A_LEVEL 8'h04
`define CCTI_A_IE 8'h05
`define CCTI_A_FLAG 8'h06
`define CCTI_A_OVF 8'h07
`define CCTI_A_CNT 8'h08
`define CCTI_A_MASK3 8'h09
`define CCTI_A_DATA3 8'h0A
`define CCTI_A_LATCH 8'h0B
`define CCTI_A_EDGE 8'h0C
`define CCTI_A_PINS 8'h0D
`define CCTI_A_TC0 8'h10
`define CCTI_A_TC_MASK 8'hFC

// Control register fields
`define CCTI_F_DIV_HI 2
`define CCTI_F_DIV_LO 0
`define CCTI_F_COUNTER_RESET_ENABLE 3
`define CCTI_F_FFCA 4
`define CCTI_F_TOI 5
`define CCTI_F_TEN 7

// Reset and fixed values
`define CCTI_CTRL_RST 8'h00
`define CCTI_EDGE_RST 8'h00
`define CCTI_NIB_RST 4'h0
`define CCTI_ZERO16 16'h0000
`define CCTI_CNT_MAX 16'hFFFF
`define CCTI_PRE_MAX 7'h7F
`define CCTI_DIV_TOP 3'h7

// Compare actions, {mode, level}
`define CCTI_ACT_NONE 2'h0
`define CCTI_ACT_TOGGLE 2'h1
`define CCTI_ACT_CLEAR 2'h2
`define CCTI_ACT_SET 2'h3

`endif

// [hdl/ccti_edge.v]
// Pin synchroniser and edge detector for one timer channel.
// Assumes pin_in is asynchronous to mclk_in.
`timescale 1ns/10ps
module ccti_edge (
	// Clock, reset, enable
	input wire mclk_in,
	input wire nrst_in,
	input wire ce_in,
	// Pin and detected events
	input wire pin_in,
	output wire level_out,
	output wire rise_out,
	output wire fall_out
);

reg sync1;
reg sync2;
reg last;

// Pulses shorter than one clock may be missed here
always @(posedge mclk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		sync1 <= 1'b0;
		sync2 <= 1'b0;
		last <= 1'b0;
	end else if (ce_in) begin
		sync1 <= pin_in;
		sync2 <= sync1;
		last <= sync2;
	end
end

assign level_out = sync2;
assign rise_out = sync2 & ~last;
assign fall_out = ~sync2 & last;

endmodule

// [testbench/ccti_timer_properties.sv]
// Checker for the timer register port, pin enables and interrupts.
// Assumes a bind onto ccti_timer; sees only its ports.
`timescale 1ns/10ps
`include "ccti_defs.vh"
module ccti_timer_chk #(
	parameter PRE_W = `CCTI_PRE_W
) (
	// Clock, reset, enable
	input wire mclk_in,
	input wire nrst_in,
	input wire ce_in,
	// Register port
	input wire [`CCTI_AW-1:0] addr_in,
	input wire [`CCTI_DW-1:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	input wire [`CCTI_DW-1:0] rd_data_out,
	// Pins and interrupts
	input wire [`CCTI_NCH-1:0] pin_in,
	input wire [`CCTI_NCH-1:0] pin_out,
	input wire [`CCTI_NCH-1:0] pin_oe_out,
	input wire [`CCTI_NCH-1:0] chan_irq_out,
	input wire ovf_irq_out
);
	wire w = ce_in && wr_in;
	reg [3:0] ie;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////////////
	// Enable copy; a request follows an enable write at the same edge
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ie <= 4'h0;
		end else begin
			if (w && addr_in == `CCTI_A_IE)
				ie <= wr_data_in[3:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	AST_OE_DIR: assert property (
		w && addr_in == `CCTI_A_DIR |=> pin_oe_out == $past(wr_data_in[3:0]))
		else $error("pin enable differs from direction");
	AST_OE_HOLD: assert property (
		!(w && addr_in == `CCTI_A_DIR) |=> $stable(pin_oe_out))
		else $error("pin enable moved without direction write");
	AST_IRQ_GATED: assert property (
		(chan_irq_out & ~ie) == 4'h0)
		else $error("channel request without its enable");
	AST_IE_OFF: assert property (
		w && addr_in == `CCTI_A_IE && wr_data_in[3:0] == 4'h0
		|=> chan_irq_out == 4'h0) else $error("request stays when disabled");
	AST_FLAG_CLR: assert property (
		w && addr_in == `CCTI_A_FLAG && wr_data_in[3:0] == 4'hF
		|=> chan_irq_out == 4'h0) else $error("request stays after clear");
	AST_FORCE_NOFLAG: assert property (
		w && addr_in == `CCTI_A_FORCE
		|=> (chan_irq_out & ~$past(chan_irq_out)) == 4'h0)
		else $error("forced compare raised a request");
	AST_OVF_OFF: assert property (
		w && addr_in == `CCTI_A_CTRL && !wr_data_in[`CCTI_F_TOI]
		|=> !ovf_irq_out) else $error("overflow request while disabled");
	AST_OVF_CLR: assert property (
		w && addr_in == `CCTI_A_OVF && wr_data_in[0] |=> !ovf_irq_out)
		else $error("overflow request after flag clear");
endmodule

// [testbench/ccti_pins_model.sv]
// External pin sources for the timer channels.
// Assumes one-cycle pulse requests from the bench on mclk_in.
`timescale 1ns/10ps
module ccti_pins_model (
	// Clock, reset
	input wire mclk_in,
	input wire nrst_in,
	// Requests and design drive
	input wire [3:0] pulse_in,
	input wire [3:0] drv_in,
	input wire [3:0] oe_in,
	// Resolved pin levels
	output wire [3:0] pin_out
);
	reg [3:0] h1;
	reg [3:0] h2;
	reg [3:0] h3;
	// Three cycles high, longer than the one-clock minimum
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			h1 <= 4'h0;
			h2 <= 4'h0;
			h3 <= 4'h0;
		end else begin
			h1 <= pulse_in;
			h2 <= h1;
			h3 <= h2;
		end
	end
	assign pin_out = (oe_in & drv_in) | (~oe_in & (h1 | h2 | h3));
endmodule

// [testbench/ccti_timer_tb.sv]
// Self-checking bench for the four-channel capture/compare timer.
// Assumes the timer ports only; reads checked from a queue of notes.
`timescale 1ns/10ps
`include "ccti_defs.vh"
module ccti_timer_tb;
	reg mclk_in = 1'b0;
	reg nrst_in = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [15:0] wdata = 16'h0000;
	reg wr_s = 1'b0;
	reg rd_s = 1'b0;
	reg ce = 1'b1;
	reg rd_seen = 1'b0;
	reg [3:0] pulse = 4'h0;
	wire [3:0] pin_w, pin_drv, pin_oe, irq;
	wire [15:0] rd_data;
	wire ovf_irq;
	logic [39:0] q[$];
	logic [39:0] ent;
	logic [15:0] rd_last, base;
	logic [16:0] seed = 17'd86280;
	int n_errors = 0;
	int checks_done = 0;
	int i;
	ccti_timer u_ccti_timer (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.ce_in(ce), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr_s),
		.rd_in(rd_s), .rd_data_out(rd_data), .pin_in(pin_w),
		.pin_out(pin_drv), .pin_oe_out(pin_oe), .chan_irq_out(irq),
		.ovf_irq_out(ovf_irq));
	ccti_pins_model u_ccti_pins_model (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.pulse_in(pulse), .drv_in(pin_drv), .oe_in(pin_oe), .pin_out(pin_w));
	initial forever #2.5 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////////
	function logic [16:0] lfsr(input logic [16:0] s);
		lfsr = {s[15:0], s[16] ^ s[13]};
	endfunction
	task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
		checks_done++;
		if (seen !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk_in);
		wr_s <= 1'b0;
	endtask
	// Mask zero: value only kept in rd_last
	task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge mclk_in);
		addr <= a;
		rd_s <= 1'b1;
		q.push_back({a, m, e});
		@(posedge mclk_in);
		rd_s <= 1'b0;
	endtask
	task settle;
		repeat (2) @(negedge mclk_in);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_in) rd_seen <= rd_s;
	always @(negedge mclk_in) begin
		if (rd_seen) begin
			rd_last = rd_data;
			ent = q.pop_front();
			if (ent[31:16] != 16'h0000)
				chk($sformatf("read %h", ent[39:32]), rd_data & ent[31:16],
					ent[15:0]);
		end
	end
	initial begin
		repeat (100000) @(posedge mclk_in);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge mclk_in);
		nrst_in <= 1'b1;
		chk("outs", {pin_drv, pin_oe, irq, 3'h0, ovf_irq}, 16'h0000);
		rd(`CCTI_A_CNT, 16'hFFFF, 16'h0000);
		wr(`CCTI_A_TC0, 16'h1234);
		rd(`CCTI_A_TC0, 16'hFFFF, 16'h0000);
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(`CCTI_A_MODE + i[7:0], seed[15:0]);
			rd(`CCTI_A_MODE + i[7:0], 16'hFFFF, 16'(seed[3:0]));
		end
		wr(`CCTI_A_DIR, 16'h000F);
		settle();
		chk("oe", 16'(pin_oe), 16'h000F);
		for (i = 0; i < 3; i++)
			wr(`CCTI_A_TC0 + i[7:0], 16'h0010);
		wr(`CCTI_A_TC0 + 8'h03, 16'h8000);
		wr(`CCTI_A_MODE, 16'h0005);
		wr(`CCTI_A_LEVEL, 16'h0003);
		wr(`CCTI_A_LATCH, 16'h000C);
		wr(`CCTI_A_IE, 16'h0001);
		wr(`CCTI_A_FLAG, 16'h000F);
		wr(`CCTI_A_CTRL, 16'h0080);
		repeat (40) @(posedge mclk_in);
		settle();
		chk("pins", 16'(pin_drv), 16'h000B);
		chk("irq", 16'(irq), 16'h0001);
		rd(`CCTI_A_FLAG, 16'hFFFF, 16'h0007);
		wr(`CCTI_A_FLAG, 16'h0001);
		settle();
		chk("irq", 16'(irq), 16'h0000);
		// Timer stopped so forces never meet a real match
		wr(`CCTI_A_CTRL, 16'h0000);
		wr(`CCTI_A_MASK3, 16'h0002);
		wr(`CCTI_A_DATA3, 16'h0000);
		// Enable channel 3 so a forced compare could show a request
		wr(`CCTI_A_IE, 16'h0008);
		wr(`CCTI_A_FORCE, 16'h0008);
		settle();
		chk("pins", 16'(pin_drv), 16'h0009);
		wr(`CCTI_A_FORCE, 16'h0002);
		settle();
		chk("pins", 16'(pin_drv), 16'h000B);
		rd(`CCTI_A_FLAG, 16'hFFFF, 16'h0006);
		chk("irq", 16'(irq), 16'h0000);
		wr(`CCTI_A_IE, 16'h0001);
		wr(`CCTI_A_TC0 + 8'h03, 16'h0003);
		wr(`CCTI_A_CTRL, 16'h00A8);
		i = 0;
		while (ovf_irq !== 1'b1 && i < 70000) begin
			@(posedge mclk_in);
			i++;
		end
		settle();
		chk("ovf irq", 16'(ovf_irq), 16'h0001);
		repeat (20) @(posedge mclk_in);
		rd(`CCTI_A_CNT, 16'hFFFC, 16'h0000);
		rd(`CCTI_A_OVF, 16'hFFFF, 16'h0001);
		wr(`CCTI_A_CTRL, 16'h00B8);
		rd(`CCTI_A_CNT, 16'h0000, 16'h0000);
		rd(`CCTI_A_OVF, 16'hFFFF, 16'h0000);
		wr(`CCTI_A_OVF, 16'h0001);
		settle();
		chk("ovf irq", 16'(ovf_irq), 16'h0000);
		wr(`CCTI_A_DIR, 16'h000E);
		wr(`CCTI_A_EDGE, 16'h0001);
		wr(`CCTI_A_FLAG, 16'h000F);
		pulse <= 4'h1;
		@(posedge mclk_in);
		pulse <= 4'h0;
		repeat (10) @(posedge mclk_in);
		rd(`CCTI_A_FLAG, 16'h0001, 16'h0001);
		rd(`CCTI_A_TC0, 16'hFFFC, 16'h0000);
		wr(`CCTI_A_TC0, 16'h1234);
		rd(`CCTI_A_TC0, 16'hFFFC, 16'h0000);
		settle();
		chk("irq", 16'(irq), 16'h0001);
		wr(`CCTI_A_IE, 16'h0000);
		settle();
		chk("irq", 16'(irq), 16'h0000);
		for (i = 0; i < 8; i++) begin
			wr(`CCTI_A_CTRL, 16'h0080 | 16'(i));
			repeat (260) @(posedge mclk_in);
			rd(`CCTI_A_CNT, 16'h0000, 16'h0000);
			@(negedge mclk_in);
			#1 base = rd_last;
			repeat ((3 << i) - 2) @(posedge mclk_in);
			rd(`CCTI_A_CNT, 16'h0000, 16'h0000);
			@(negedge mclk_in);
			#1 chk("div", rd_last - base, 16'h0003);
		end
		// Clock enable low for 20 edges freezes the counter
		wr(`CCTI_A_CTRL, 16'h0080);
		rd(`CCTI_A_CNT, 16'h0000, 16'h0000);
		@(negedge mclk_in);
		#1 base = rd_last;
		@(posedge mclk_in);
		ce <= 1'b0;
		repeat (20) @(posedge mclk_in);
		ce <= 1'b1;
		rd(`CCTI_A_CNT, 16'h0000, 16'h0000);
		@(negedge mclk_in);
		#1 chk("freeze", rd_last - base, 16'h0003);
		end_of_test();
	end
endmodule
bind ccti_timer ccti_timer_chk #(.PRE_W(PRE_W)) u_ccti_timer_chk (
	.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .addr_in(addr_in),
	.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
	.rd_data_out(rd_data_out), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe_out(pin_oe_out), .chan_irq_out(chan_irq_out),
	.ovf_irq_out(ovf_irq_out));
